// file: rtl/iap_pkg.sv
package iap_pkg;
  // ****************************************
  // Register selects on the SFR port
  // ****************************************
  localparam logic [3:0] REG_CTRL0    = 4'h0;
  localparam logic [3:0] REG_CTRL2    = 4'h1;
  localparam logic [3:0] REG_ADDR_LO  = 4'h2;
  localparam logic [3:0] REG_ADDR_HI  = 4'h3;
  localparam logic [3:0] REG_W0_LO    = 4'h4;
  localparam logic [3:0] REG_W0_HI    = 4'h5;
  localparam logic [3:0] REG_W1_LO    = 4'h6;
  localparam logic [3:0] REG_W1_HI    = 4'h7;
  localparam logic [3:0] REG_W2_LO    = 4'h8;
  localparam logic [3:0] REG_W2_HI    = 4'h9;
  localparam logic [3:0] REG_W3_LO    = 4'ha;
  localparam logic [3:0] REG_W3_HI    = 4'hb;
  // ****************************************
  // Control field positions
  // ****************************************
  localparam int unsigned CTL_ENABLED_BIT = 7;
  localparam int unsigned CTL_MODE_LSB    = 4;
  localparam int unsigned CTL_TRIGGER_BIT = 3;
  localparam int unsigned CTL_START_BIT   = 2;
  localparam int unsigned CLR_BUF_BIT     = 0;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // ****************************************
  // Modes and key
  // ****************************************
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] KEY_W1_LO   = 8'h00;
  localparam logic [7:0] KEY_W2_LO   = 8'h0d;
  localparam logic [7:0] KEY_W3_LO   = 8'hc3;
  localparam logic [7:0] KEY_W1_HI   = 8'h04;
  localparam logic [7:0] KEY_W2_HI   = 8'h09;
  localparam logic [7:0] KEY_W3_HI   = 8'h40;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned PAGE_WORDS = 32;
  localparam int unsigned OFS_W      = 5;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned UNLOCK_WINDOW_NS = 10000;
  localparam int unsigned ERASE_TIME_NS    = 20000;
  localparam int unsigned PROG_TIME_NS     = 20000;
  localparam int unsigned UNLOCK_CYC = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC  = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC   = PROG_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {IAP_IDLE, IAP_ERASE, IAP_PROG} iap_state_e;
endpackage

// file: rtl/iap_buf_if.sv
`timescale 1ns/1ps
interface iap_buf_if;
  logic        clr;
  logic        load;
  logic [4:0]  load_idx;
  logic [15:0] load_data;
  logic [4:0]  rd_idx;
  logic [15:0] rd_data;
  logic        rd_tag;
  modport owner (output clr, load, load_idx, load_data, rd_idx, input rd_data, rd_tag);
  modport store (input clr, load, load_idx, load_data, rd_idx, output rd_data, rd_tag);
endinterface

// file: rtl/iap_page_buf.sv
`timescale 1ns/1ps
module iap_page_buf #(
  parameter int unsigned WORDS = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  iap_buf_if.store bus
);
  import iap_pkg::*;
  logic [15:0]      mem_q [WORDS];
  logic [15:0]      mem_d [WORDS];
  logic [WORDS-1:0] tag_q;
  logic [WORDS-1:0] tag_d;

  // Words are tagged as loaded; erase and program touch tagged words only
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_comb begin
        mem_d[g] = mem_q[g];
        tag_d[g] = tag_q[g];
        if (bus.clr) begin
          mem_d[g] = 16'h0000;
          tag_d[g] = 1'b0;
        end else if (bus.load && bus.load_idx == OFS_W'(g)) begin
          mem_d[g] = bus.load_data;
          tag_d[g] = 1'b1;
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_q[g] <= 16'h0000;
          tag_q[g] <= 1'b0;
        end else begin
          mem_q[g] <= mem_d[g];
          tag_q[g] <= tag_d[g];
        end
      end
    end
  endgenerate

  assign bus.rd_data = mem_q[bus.rd_idx];
  assign bus.rd_tag  = tag_q[bus.rd_idx];
endmodule

// file: rtl/iap_flash_seq.sv
`timescale 1ns/1ps
module iap_flash_seq
  import iap_pkg::*;
#(
  parameter int unsigned UNLOCK_CYCLES = iap_pkg::UNLOCK_CYC,
  parameter int unsigned ERASE_CYCLES  = iap_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYCLES   = iap_pkg::PROG_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sfr_wr,
  input  wire logic [3:0]  sfr_sel,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  output logic             cpu_stall,
  output logic             fl_wr,
  output logic             fl_erase,
  output logic [13:0]      fl_addr,
  output logic [15:0]      fl_wdata
);
  import iap_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  ctl_q, ctl_d;
  logic        clr_q, clr_d;
  logic [13:0] addr_q, addr_d;
  logic [7:0]  dat_q [8];
  logic [7:0]  dat_d [8];
  logic [31:0] tmr_q, tmr_d;
  logic [4:0]  idx_q, idx_d;
  iap_state_e  st_q, st_d;
  logic [7:0]  rd_q, rd_d;
  logic        stall_q, stall_d;
  logic        fwr_q, fwr_d, fer_q, fer_d;
  logic        scan_done_q, scan_done_d;
  logic [13:0] fa_q, fa_d;
  logic [15:0] fd_q, fd_d;
  logic        wr_hi0;
  logic        key_match;
  logic [2:0]  mode;
  iap_buf_if   bufb();

  function automatic logic hit(input logic [3:0] s, input logic [3:0] r);
    hit = sfr_wr && (s == r);
  endfunction

  assign mode   = ctl_q[CTL_MODE_LSB +: 3];
  assign wr_hi0 = hit(sfr_sel, REG_W0_HI);
  // key bytes, word1..word3 low then high
  assign key_match = (dat_q[2] == KEY_W1_LO) && (dat_q[4] == KEY_W2_LO)
                     && (dat_q[6] == KEY_W3_LO) && (dat_q[3] == KEY_W1_HI)
                     && (dat_q[5] == KEY_W2_HI) && (dat_q[7] == KEY_W3_HI);

  iap_page_buf #(.WORDS(PAGE_WORDS)) u_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (bufb)
  );

  // ****************************************
  // Register and sequencer next state
  // ****************************************
  always_comb begin
    ctl_d    = ctl_q;
    clr_d    = 1'b0;
    addr_d   = addr_q;
    for (int i = 0; i < 8; i++) dat_d[i] = dat_q[i];
    tmr_d    = tmr_q;
    idx_d    = idx_q;
    st_d     = st_q;
    stall_d  = 1'b0;
    fwr_d    = 1'b0;
    fer_d    = 1'b0;
    fa_d     = fa_q;
    fd_d     = fd_q;
    scan_done_d = scan_done_q;
    bufb.clr       = clr_q;
    bufb.load      = 1'b0;
    bufb.load_idx  = addr_q[4:0];
    bufb.load_data = {dat_q[1], dat_q[0]};
    bufb.rd_idx    = idx_q;
    if (sfr_wr && st_q == IAP_IDLE) begin
      case (sfr_sel)
        REG_CTRL0: begin
          ctl_d[CTL_ENABLED_BIT] = ctl_q[CTL_ENABLED_BIT] & sfr_wdata[CTL_ENABLED_BIT];
          ctl_d[6:0] = sfr_wdata[6:0];
          if (sfr_wdata[CTL_TRIGGER_BIT] && !ctl_q[CTL_TRIGGER_BIT]) begin
            if (sfr_wdata[CTL_MODE_LSB +: 3] == MODE_UNLOCK) begin
              tmr_d = UNLOCK_CYCLES;
            end else begin
              ctl_d[CTL_TRIGGER_BIT] = 1'b0;
            end
          end
          if (!ctl_q[CTL_TRIGGER_BIT] && !sfr_wdata[CTL_TRIGGER_BIT]) ctl_d[3] = 1'b0;
          if (ctl_q[CTL_TRIGGER_BIT]) ctl_d[CTL_TRIGGER_BIT] = 1'b1;
        end
        REG_CTRL2:   clr_d = sfr_wdata[CLR_BUF_BIT];
        REG_ADDR_LO: addr_d[7:0] = sfr_wdata;
        REG_ADDR_HI: addr_d[13:8] = sfr_wdata[5:0];
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (sfr_sel == REG_W0_LO + 4'(i)) dat_d[i] = sfr_wdata;
          end
        end
      endcase
    end
    // load word and tag, then advance unless at page end
    if (wr_hi0 && st_q == IAP_IDLE && ctl_q[CTL_ENABLED_BIT]
        && (mode == MODE_ERASE || mode == MODE_WRITE)) begin
      bufb.load      = 1'b1;
      bufb.load_data = {sfr_wdata, dat_q[0]};
      if (addr_q[4:0] != 5'h1f) addr_d = addr_q + 14'h0001;
    end
    if (ctl_q[CTL_TRIGGER_BIT]) begin
      if (tmr_q <= 32'h1) begin
        ctl_d[CTL_TRIGGER_BIT] = 1'b0;
        tmr_d = 32'h0;
        if (key_match && mode == MODE_UNLOCK)
          ctl_d[CTL_ENABLED_BIT] = 1'b1;
      end else begin
        tmr_d = tmr_q - 32'h1;
      end
    end
    case (st_q)
      IAP_IDLE: begin
        if (hit(sfr_sel, REG_CTRL0) && sfr_wdata[CTL_START_BIT]) begin
          // Start refused while locked or in another mode
          if (ctl_q[CTL_ENABLED_BIT] && sfr_wdata[CTL_MODE_LSB +: 3] == MODE_ERASE) begin
            st_d = IAP_ERASE;
            tmr_d = ERASE_CYCLES;
            scan_done_d = 1'b0;
            idx_d = 5'h00;
            stall_d = 1'b1;
          end else if (ctl_q[CTL_ENABLED_BIT]
                       && sfr_wdata[CTL_MODE_LSB +: 3] == MODE_WRITE) begin
            st_d = IAP_PROG;
            tmr_d = PROG_CYCLES;
            scan_done_d = 1'b0;
            idx_d = 5'h00;
            stall_d = 1'b1;
          end else begin
            ctl_d[CTL_START_BIT] = 1'b0;
          end
        end
      end
      IAP_ERASE, IAP_PROG: begin
        stall_d = 1'b1;
        // one strobe per tagged word of the page
        fa_d = {addr_q[13:5], idx_q};
        fd_d = bufb.rd_data;
        // Scan parks on the last word until the timer ends, so strobe it only once
        if (bufb.rd_tag && !scan_done_q) begin
          fer_d = (st_q == IAP_ERASE);
          fwr_d = (st_q == IAP_PROG);
        end
        if (idx_q == 5'h1f) scan_done_d = 1'b1;
        if (idx_q != 5'h1f) idx_d = idx_q + 5'h01;
        if (tmr_q <= 32'h1 && idx_q == 5'h1f) begin
          ctl_d[CTL_START_BIT] = 1'b0;
          st_d = IAP_IDLE;
          stall_d = 1'b0;
          tmr_d = 32'h0;
        end else if (tmr_q > 32'h1) begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      default: st_d = IAP_IDLE;
    endcase
    // locked device clears the start bit while idle
    if (!ctl_d[CTL_ENABLED_BIT] && st_q == IAP_IDLE) ctl_d[CTL_START_BIT] = 1'b0;
  end

  always_comb begin
    rd_d = REG_RESET;
    case (sfr_sel)
      REG_CTRL0:   rd_d = ctl_q;
      REG_CTRL2:   rd_d = {7'h00, clr_q};
      REG_ADDR_LO: rd_d = addr_q[7:0];
      REG_ADDR_HI: rd_d = {2'b00, addr_q[13:8]};
      default: begin
        for (int i = 0; i < 8; i++) begin
          if (sfr_sel == REG_W0_LO + 4'(i)) rd_d = dat_q[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q   <= REG_RESET;
      clr_q   <= 1'b0;
      addr_q  <= 14'h0000;
      for (int i = 0; i < 8; i++) dat_q[i] <= REG_RESET;
      tmr_q   <= 32'h0;
      idx_q   <= 5'h00;
      st_q    <= IAP_IDLE;
      rd_q    <= REG_RESET;
      stall_q <= 1'b0;
      fwr_q   <= 1'b0;
      fer_q   <= 1'b0;
      fa_q    <= 14'h0000;
      fd_q    <= 16'h0000;
      scan_done_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      clr_q   <= clr_d;
      addr_q  <= addr_d;
      for (int i = 0; i < 8; i++) dat_q[i] <= dat_d[i];
      tmr_q   <= tmr_d;
      idx_q   <= idx_d;
      st_q    <= st_d;
      rd_q    <= rd_d;
      stall_q <= stall_d;
      fwr_q   <= fwr_d;
      fer_q   <= fer_d;
      fa_q    <= fa_d;
      fd_q    <= fd_d;
      scan_done_q <= scan_done_d;
    end
  end

  assign sfr_rdata = rd_q;
  assign cpu_stall = stall_q;
  assign fl_wr     = fwr_q;
  assign fl_erase  = fer_q;
  assign fl_addr   = fa_q;
  assign fl_wdata  = fd_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_flag_no_sw_set: assert property (
    !ctl_q[7] && sfr_wr && sfr_sel == REG_CTRL0 && !ctl_q[3] |=> !ctl_q[7])
    else $error("enabled flag set by software");
  a_flag_sw_clear: assert property (
    ctl_q[7] && sfr_wr && sfr_sel == REG_CTRL0 && !sfr_wdata[7] && !ctl_q[3] |=> !ctl_q[7])
    else $error("enabled flag not cleared");
  a_trig_clears: assert property (
    ctl_q[3] && tmr_q == 32'h1 |=> !ctl_q[3])
    else $error("trigger not cleared at expiry");
  a_no_op_locked: assert property (
    st_q == IAP_IDLE && !ctl_q[7] |=> st_q == IAP_IDLE)
    else $error("operation while locked");
  a_tag_hold: assert property (
    wr_hi0 && st_q == IAP_IDLE && addr_q[4:0] == 5'h1f |=> $stable(addr_q))
    else $error("address passed page end");
  a_stall_busy: assert property (
    st_q != IAP_IDLE |=> cpu_stall || st_q == IAP_IDLE)
    else $error("cpu not stalled");
  a_page_bound: assert property (
    fl_wr || fl_erase |-> fl_addr[13:5] == addr_q[13:5])
    else $error("strobe outside page");
  a_start_done: assert property (
    st_q != IAP_IDLE ##1 st_q == IAP_IDLE |-> !ctl_q[2])
    else $error("start bit left set");

  sequence s_window_end;
    ctl_q[CTL_TRIGGER_BIT] && tmr_q == 32'h1;
  endsequence
  sequence s_erase_req;
    st_q == IAP_IDLE && ctl_q[CTL_ENABLED_BIT] && sfr_wr && sfr_sel == REG_CTRL0
      && sfr_wdata[CTL_START_BIT] && sfr_wdata[CTL_MODE_LSB +: 3] == MODE_ERASE;
  endsequence
  sequence s_erase_busy;
    st_q == IAP_ERASE && cpu_stall;
  endsequence
  a_key_accept: assert property (
    s_window_end ##0 (key_match && mode == MODE_UNLOCK) |=> ctl_q[CTL_ENABLED_BIT])
    else $error("flag not set by good key");
  a_key_reject: assert property (
    s_window_end ##0 (!key_match && !ctl_q[CTL_ENABLED_BIT]) |=> !ctl_q[CTL_ENABLED_BIT])
    else $error("flag set by bad key");
  a_erase_start: assert property (
    s_erase_req |=> s_erase_busy)
    else $error("erase not started");
  a_locked_refuse: assert property (
    st_q == IAP_IDLE && !ctl_q[CTL_ENABLED_BIT] && sfr_wr && sfr_sel == REG_CTRL0
    |=> !ctl_q[CTL_START_BIT] && !cpu_stall)
    else $error("start accepted while locked");
  a_strobe_once: assert property (
    fl_wr || fl_erase |=> !(fl_wr || fl_erase) || fl_addr != $past(fl_addr))
    else $error("word strobed twice");
endmodule

// file: tb/iap_flash_model.sv
`timescale 1ns/1ps
module iap_flash_model (
  input  wire logic        clk,
  input  wire logic        fl_wr,
  input  wire logic        fl_erase,
  input  wire logic [13:0] fl_addr,
  input  wire logic [15:0] fl_wdata,
  input  wire logic [13:0] tbl_addr,
  output logic      [15:0] tbl_data
);
  logic [15:0] mem_q [16384];
  // ****************************************
  // Array cells
  // ****************************************
  // Cells start away from the blank value, so a missed erase shows up
  initial begin
    foreach (mem_q[i]) begin
      mem_q[i] = 16'hffff;
    end
  end
  always @(posedge clk) begin
    if (fl_erase) begin
      mem_q[fl_addr] <= 16'h0000;
    end else if (fl_wr) begin
      mem_q[fl_addr] <= fl_wdata;
    end
  end
  assign tbl_data = mem_q[tbl_addr];
endmodule

// file: tb/iap_flash_erase_write_tb.sv
`timescale 1ns/1ps
module iap_flash_erase_write_tb;
  import iap_pkg::*;
  localparam int unsigned SIM_CYC = 40;
  localparam logic [3:0] KSEL [6] = '{REG_W1_LO, REG_W2_LO, REG_W3_LO,
                                      REG_W1_HI, REG_W2_HI, REG_W3_HI};
  localparam logic [7:0] KVAL [6] = '{KEY_W1_LO, KEY_W2_LO, KEY_W3_LO,
                                      KEY_W1_HI, KEY_W2_HI, KEY_W3_HI};
  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        sfr_wr    = 1'b0;
  logic [3:0]  sfr_sel   = 4'h0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [13:0] tbl_addr  = 14'h0000;
  logic [7:0]  sfr_rdata;
  logic        cpu_stall;
  logic        fl_wr;
  logic        fl_erase;
  logic [13:0] fl_addr;
  logic [15:0] fl_wdata;
  logic [15:0] tbl_data;
  int          n_errors  = 0;
  int          compares  = 0;
  logic [31:0] exp_q [$];
  logic [31:0] mon_e;
  logic [15:0] buf_d [32];
  bit          buf_t [32];
  logic [13:0] addr_m;
  logic [31:0] r;
  logic [7:0]  v;
  always #5 clk = ~clk;
  iap_flash_seq #(.UNLOCK_CYCLES(SIM_CYC), .ERASE_CYCLES(SIM_CYC), .PROG_CYCLES(SIM_CYC)) DUT (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sfr_wr    (sfr_wr),
    .sfr_sel   (sfr_sel),
    .sfr_wdata (sfr_wdata),
    .sfr_rdata (sfr_rdata),
    .cpu_stall (cpu_stall),
    .fl_wr     (fl_wr),
    .fl_erase  (fl_erase),
    .fl_addr   (fl_addr),
    .fl_wdata  (fl_wdata)
  );
  iap_flash_model u_flash (
    .clk      (clk),
    .fl_wr    (fl_wr),
    .fl_erase (fl_erase),
    .fl_addr  (fl_addr),
    .fl_wdata (fl_wdata),
    .tbl_addr (tbl_addr),
    .tbl_data (tbl_data)
  );
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    @(posedge clk);
    sfr_wr    <= 1'b1;
    sfr_sel   <= sel;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] sel, output logic [7:0] d);
    @(posedge clk);
    sfr_sel <= sel;
    repeat (2) @(posedge clk);
    #1;
    d = sfr_rdata;
  endtask
  task automatic set_addr(input logic [13:0] a);
    wr(REG_ADDR_LO, a[7:0]);
    wr(REG_ADDR_HI, {2'b00, a[13:8]});
    addr_m = a;
  endtask
  task automatic clr_buf();
    wr(REG_CTRL2, 8'h01);
    foreach (buf_t[i]) begin
      buf_t[i] = 1'b0;
    end
  endtask
  // load at offset, advance unless at page end
  task automatic load(input logic [15:0] w);
    wr(REG_W0_LO, w[7:0]);
    wr(REG_W0_HI, w[15:8]);
    buf_d[addr_m[4:0]] = w;
    buf_t[addr_m[4:0]] = 1'b1;
    if (addr_m[4:0] != 5'h1f) begin
      addr_m = addr_m + 14'h0001;
    end
  endtask
  task automatic unlock(input int bad);
    wr(REG_CTRL0, 8'h60);
    wr(REG_CTRL0, 8'h68);
    rd(REG_CTRL0, v);
    check("trigger", 8'h68, v);
    for (int i = 0; i < 6; i++) begin
      r = $urandom_range(255, 1);
      wr(KSEL[i], (i == bad) ? (KVAL[i] ^ r[7:0]) : KVAL[i]);
    end
    repeat (SIM_CYC + 4) @(posedge clk);
    rd(REG_CTRL0, v);
    check("unlock", {bad == 6, 7'h60}, {24'h0, v});
  endtask
  task automatic run(input logic [2:0] mode);
    bit done;
    done = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (buf_t[i]) begin
        exp_q.push_back({1'b1, mode == MODE_ERASE, addr_m[13:5], i[4:0],
                         (mode == MODE_ERASE) ? 16'h0000 : buf_d[i]});
      end
    end
    wr(REG_CTRL0, {1'b1, mode, 4'h4});
    @(posedge clk);
    #1;
    check("stall", 1, cpu_stall);
    for (int i = 0; i < 100 && !done; i++) begin
      rd(REG_CTRL0, v);
      done = (v[2] === 1'b0);
    end
    if (!done) begin
      n_errors++;
      final_report();
    end
    check("ctrl0_done", {1'b1, mode, 4'h0}, v);
    check("strobes_left", 0, exp_q.size());
  endtask
  // Table reads of every tagged cell, as software does after each operation
  task automatic verify(input bit erase);
    for (int i = 0; i < 32; i++) begin
      if (buf_t[i]) begin
        tbl_addr = {addr_m[13:5], i[4:0]};
        #1;
        check("cell", erase ? 16'h0000 : buf_d[i], tbl_data);
      end
    end
  endtask
  // every strobe must be one expected, with the CPU held
  always @(posedge clk) begin
    if (fl_wr === 1'b1 || fl_erase === 1'b1) begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0;
      check("strobe", mon_e, {cpu_stall, fl_erase, fl_addr, fl_erase ? 16'h0 : fl_wdata});
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    void'($urandom(60));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CTRL0, v);
    check("ctrl0_rst", REG_RESET, v);
    rd(REG_W3_LO, v);
    check("w3_lo_rst", 8'h00, v);
    r = $urandom();
    wr(REG_W3_HI, r[7:0]);
    rd(REG_W3_HI, v);
    check("w3_hi", r[7:0], v);
    wr(REG_CTRL0, 8'h80);
    rd(REG_CTRL0, v);
    check("flag_sw_set", 8'h00, v);
    unlock($urandom_range(5, 0));
    unlock(6);
    wr(REG_CTRL0, 8'h90);
    clr_buf();
    r = $urandom();
    set_addr(r[13:0]);
    repeat ($urandom_range(40, 1)) load(16'h0000);
    rd(REG_ADDR_LO, v);
    check("addr_lo", addr_m[7:0], v);
    run(MODE_ERASE);
    verify(1'b1);
    wr(REG_CTRL0, 8'h80);
    clr_buf();
    set_addr({r[13:5], 5'h1d});
    for (int k = 0; k < 4; k++) begin
      r = $urandom();
      load(r[15:0]);
    end
    run(MODE_WRITE);
    verify(1'b0);
    // Third pass rewrites the same word after a buffer clear
    for (int k = 0; k < 3; k++) begin
      clr_buf();
      if (k < 2) begin
        r = $urandom();
      end else begin
        r[31:16] = ~r[31:16];
      end
      set_addr(r[13:0]);
      load(r[31:16]);
      run(MODE_WRITE);
      verify(1'b0);
    end
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL0, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    check("stall_off", 0, cpu_stall);
    rd(REG_CTRL0, v);
    check("ctrl0_off", 8'h00, v);
    final_report();
  end
endmodule
